// ### common/psr_cfg.svh
// Constants for the split and reset router controller
//
// Behaviour
// - Split request 0b000 selects one x16
// - Split request 0b110 forces four x4
// - Controller picks commonly supported arrangement
// - Non-splitting x16 host downshifts to x8
// - Clock and reset n serve link n
// - Indices 4 and 5 stay unused
// - Lanes map to links in order
// - Each x4 link has its own clock, reset
// - Second connector lanes extend the numbering
// - Dual host routes host1 to link1
// - Quad host routes host2 to link1
// - Card present only when code not 0b1111
// - Split request valid before standby power
// - Clock valid 100 us before reset release
// - Split change only via identification state
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH
`define PSR_CAP_NONE      4'hF
`define PSR_CAP_X16       4'h7
`define PSR_CAP_2X8       4'h6
`define PSR_CAP_SPLIT     4'h4
`define PSR_CAP_4X4       4'h3
`define PSR_SPLIT_X16     3'h0
`define PSR_SPLIT_4X4     3'h6
`define PSR_SPLIT_2X8     3'h1
`define PSR_REG_CTRL      4'h0
`define PSR_REG_STAT      4'h4
`define PSR_REG_ROUTE     4'h8
`define PSR_CTRL_RST      8'h00
`define PSR_CLK_MHZ       20
`define PSR_REFCLK_US     100
`define PSR_REFCLK_CYC    (`PSR_REFCLK_US * `PSR_CLK_MHZ)
`define PSR_RESP_OKAY     2'h0
`define PSR_RESP_SLVERR   2'h2
`endif

// ### common/psr_pkg.sv
// Types for the split and reset router controller
`default_nettype none
package psr_pkg;
   typedef enum logic [2:0] {
      PSR_OFF     = 3'h0,
      PSR_IDENT   = 3'h1,
      PSR_STANDBY = 3'h2,
      PSR_CLKWAIT = 3'h3,
      PSR_RUN     = 3'h4
   } psr_state_e;
   typedef enum logic [1:0] {
      PSR_ARR_NONE = 2'h0,
      PSR_ARR_1X16 = 2'h1,
      PSR_ARR_2X8  = 2'h2,
      PSR_ARR_4X4  = 2'h3
   } psr_arr_e;
endpackage : psr_pkg
`default_nettype wire

// ### rtl/psr_router.sv
// Baseboard controller for card link split, clock and reset routing
`include "psr_cfg.svh"
`default_nettype none
module psr_router
   import psr_pkg::*;
#(
   parameter int REFCLK_CYC = `PSR_REFCLK_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [3:0]  card_capability_code,
   output logic [2:0]       host_split_request,
   output logic             standby_power_enable,
   output logic [5:0]       link_refclk_en,
   output logic [5:0]       link_reset_n,
   output logic [1:0]       link1_src_host
);
   // Control register fields
   logic       enable_q;
   logic       force_4x4_q;
   logic       no_split_q;
   logic [1:0] hosts_q;
   logic       reident_q;
   // Bus state
   logic       aw_q;
   logic       w_q;
   logic [3:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   // Sequencing
   psr_state_e state_q;
   psr_arr_e   arr_q;
   psr_arr_e   arr_d;
   logic [2:0] split_d;
   logic [$clog2(REFCLK_CYC+1)-1:0] cnt_q;
   logic [3:0] cap_s;
   logic       present;
   logic       wr_fire;
   logic [1:0] link1_d;

   psr_sync #(.W(4)) u_cap_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .din     (card_capability_code),
      .rst_val (`PSR_CAP_NONE),
      .dout    (cap_s)
   );

   assign present = (cap_s != `PSR_CAP_NONE);

   // Arrangement resolution against the card code
   always_comb begin
      arr_d   = PSR_ARR_NONE;
      split_d = `PSR_SPLIT_X16;
      unique case (cap_s)
         `PSR_CAP_X16: begin
            arr_d = PSR_ARR_1X16;
         end
         `PSR_CAP_2X8: begin
            // Non-splitting host keeps endpoint 0 only
            arr_d = no_split_q ? PSR_ARR_1X16 : PSR_ARR_2X8;
         end
         `PSR_CAP_SPLIT: begin
            if (force_4x4_q && !no_split_q) begin
               arr_d   = PSR_ARR_4X4;
               split_d = `PSR_SPLIT_4X4;
            end else begin
               arr_d   = PSR_ARR_1X16;
            end
         end
         `PSR_CAP_4X4: begin
            // Fixed card; split request left at default
            arr_d = no_split_q ? PSR_ARR_1X16 : PSR_ARR_4X4;
         end
         default: begin
            arr_d = PSR_ARR_NONE;
         end
      endcase
   end

   // Link 1 clock and reset source by host count
   always_comb begin
      if (arr_q == PSR_ARR_2X8 && hosts_q == 2'h1) begin
         link1_d = 2'h1;
      end else if (arr_q == PSR_ARR_2X8 && hosts_q == 2'h2) begin
         link1_d = 2'h2;
      end else begin
         link1_d = 2'h0;
      end
   end

   // Power and reset sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= PSR_OFF;
         arr_q   <= PSR_ARR_NONE;
         cnt_q   <= '0;
         host_split_request   <= `PSR_SPLIT_X16;
         standby_power_enable <= 1'b0;
         link_refclk_en       <= 6'h00;
         link_reset_n         <= 6'h00;
         link1_src_host       <= 2'h0;
      end else begin
         link1_src_host <= link1_d;
         unique case (state_q)
            PSR_OFF: begin
               if (enable_q) begin
                  state_q <= PSR_IDENT;
               end
            end
            PSR_IDENT: begin
               standby_power_enable <= 1'b0;
               link_refclk_en <= 6'h00;
               link_reset_n   <= 6'h00;
               if (!enable_q) begin
                  state_q <= PSR_OFF;
               end else if (present) begin
                  arr_q <= arr_d;
                  host_split_request <= split_d;
                  state_q <= PSR_STANDBY;
               end
            end
            PSR_STANDBY: begin
               // Split request already stable one cycle earlier
               standby_power_enable <= 1'b1;
               cnt_q <= '0;
               // One clock per link index; each x4 link has its own
               unique case (arr_q)
                  PSR_ARR_1X16: link_refclk_en <= 6'h01;
                  PSR_ARR_2X8:  link_refclk_en <= 6'h03;
                  PSR_ARR_4X4:  link_refclk_en <= 6'h0F;
                  default:      link_refclk_en <= 6'h00;
               endcase
               state_q <= PSR_CLKWAIT;
            end
            PSR_CLKWAIT: begin
               if (cnt_q >= ($clog2(REFCLK_CYC+1))'(REFCLK_CYC - 1)) begin
                  // Resets follow clocks; unused and 4..5 stay low
                  link_reset_n <= link_refclk_en & 6'h0F;
                  state_q <= PSR_RUN;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            PSR_RUN: begin
               if (reident_q || !enable_q || !present) begin
                  state_q <= PSR_IDENT;
               end
            end
            default: begin
               state_q <= PSR_OFF;
            end
         endcase
      end
   end

   // AXI4-Lite write channel
   assign wr_fire = aw_q && w_q && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q  <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `PSR_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_q && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_q && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_q <= 1'b0;
            w_q  <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q == `PSR_REG_CTRL) ? `PSR_RESP_OKAY : `PSR_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control register; re-identify bit self-clears
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_q    <= 1'b0;
         force_4x4_q <= 1'b0;
         no_split_q  <= 1'b0;
         hosts_q     <= 2'h0;
         reident_q   <= 1'b0;
      end else begin
         reident_q <= 1'b0;
         if (wr_fire && awaddr_q == `PSR_REG_CTRL && wstrb_q[0]) begin
            enable_q    <= wdata_q[0];
            force_4x4_q <= wdata_q[1];
            no_split_q  <= wdata_q[2];
            hosts_q     <= wdata_q[4:3];
            reident_q   <= wdata_q[5];
         end
      end
   end

   // AXI4-Lite read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `PSR_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `PSR_RESP_OKAY;
            unique case (s_axi_araddr)
               `PSR_REG_CTRL: s_axi_rdata <= {26'h0, 1'b0, hosts_q, no_split_q, force_4x4_q, enable_q};
               `PSR_REG_STAT: s_axi_rdata <= {22'h0, present, arr_q, state_q, cap_s};
               `PSR_REG_ROUTE: s_axi_rdata <= {14'h0, link1_src_host, link_reset_n,
                                               link_refclk_en, standby_power_enable, host_split_request};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `PSR_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : psr_router
`default_nettype wire

// ### rtl/psr_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module psr_sync #(
   parameter int W = 4
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] din,
   input  wire logic [W-1:0] rst_val,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge aclk) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end

   // Output changes only when stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dout <= rst_val;
      end else if (s2_q == s3_q) begin
         dout <= s3_q;
      end
   end
endmodule : psr_sync
`default_nettype wire

// ### test/psr_card.sv
// Card model: presents a capability code and trains links
`default_nettype none
module psr_card (
   input  wire logic [3:0] card_kind,
   input  wire logic [5:0] link_refclk_en,
   input  wire logic [5:0] link_reset_n,
   output logic      [3:0] card_capability_code,
   output logic      [3:0] link_up
);
   timeunit 1ns;
   timeprecision 1ns;
   // Kind is 7, 6, 4 or 3; pulled up to all ones when unplugged
   assign card_capability_code = card_kind;
   // Split pins left open, width follows the code
   // Link n trains on clock n and reset n only; 4 and 5 ignored
   assign link_up = link_refclk_en[3:0] & link_reset_n[3:0];
endmodule : psr_card
`default_nettype wire

// ### test/psr_router_bench.sv
// Testbench for the split and reset router
`default_nettype none
module psr_router_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int REFCLK_CYC = 20;
   logic aclk;
   logic aresetn = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0, card_kind = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, standby_power_enable;
   logic [1:0] s_axi_bresp, s_axi_rresp, link1_src_host, rs;
   logic [2:0] host_split_request;
   logic [5:0] link_refclk_en, link_reset_n;
   logic [3:0] card_capability_code, link_up;
   int miscompares = 0;
   int total_checks = 0;
   psr_router #(.REFCLK_CYC(REFCLK_CYC)) dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .card_capability_code, .host_split_request, .standby_power_enable, .link_refclk_en,
      .link_reset_n, .link1_src_host);
   psr_card card (.card_kind, .link_refclk_en, .link_reset_n, .card_capability_code, .link_up);
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   task automatic stop_test;
      if (miscompares == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ta && tw)) begin
         // Ready seen mid-cycle holds through the next edge
         @(negedge aclk);
         ta = ta | s_axi_awready;
         tw = tw | s_axi_wready;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      do @(negedge aclk); while (!s_axi_bvalid);
      rs = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rdr(input logic [3:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge aclk); while (!s_axi_arready);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask : rdr
   // Swap card while disabled, enable, then check route, status, links
   task automatic cs(input logic [3:0] cap, input logic [5:0] ctl, input logic [31:0] rte,
                     input logic [1:0] arr, input logic dc);
      wr(4'h0, 32'h0, 4'hF);
      card_kind <= 4'hF;
      repeat (10) @(posedge aclk);
      card_kind <= cap;
      repeat (10) @(posedge aclk);
      wr(4'h0, {26'h0, ctl}, 4'hF);
      repeat (40) @(posedge aclk);
      rdr(4'h8);
      chk("route", rte | {29'h0, {3{dc}}}, rd | {29'h0, {3{dc}}});
      rdr(4'h4);
      chk("status", {22'h0, 1'b1, arr, 3'h4, cap}, rd);
      chk("links", {28'h0, rte[13:10]}, {28'h0, link_up});
      chk("pins", {14'h0, rte[17:3], rte[2:0] | {3{dc}}}, {14'h0, link1_src_host, link_reset_n, link_refclk_en,
          standby_power_enable, host_split_request | {3{dc}}});
   endtask : cs
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(4'h8);
      chk("route", 32'h0, rd);
      wr(4'hC, 32'h1, 4'hF);
      chk("bresp", 32'h2, {30'h0, rs});
      rdr(4'hC);
      chk("rresp", 32'h2, {30'h0, rs});
      chk("rdata", 32'h0, rd);
      wr(4'h0, 32'h1, 4'h0);
      rdr(4'h0);
      chk("ctrl", 32'h0, rd);
      cs(4'h7, 6'h01, 32'h418, 2'h1, 1'b0);
      cs(4'h6, 6'h01, 32'hC38, 2'h2, 1'b0);
      cs(4'h6, 6'h05, 32'h418, 2'h1, 1'b0);
      cs(4'h4, 6'h03, 32'h3CFE, 2'h3, 1'b0);
      wr(4'h0, 32'h21, 4'hF);
      repeat (40) @(posedge aclk);
      rdr(4'h8);
      chk("route", 32'h418, rd);
      rdr(4'h0);
      chk("ctrl", 32'h1, rd);
      cs(4'h3, 6'h01, 32'h3CF8, 2'h3, 1'b1);
      cs(4'h6, 6'h09, 32'h10C38, 2'h2, 1'b0);
      cs(4'h6, 6'h11, 32'h20C38, 2'h2, 1'b0);
      wr(4'h0, 32'h0, 4'hF);
      card_kind <= 4'hF;
      repeat (10) @(posedge aclk);
      wr(4'h0, 32'h1, 4'hF);
      repeat (20) @(posedge aclk);
      rdr(4'h4);
      // Absent card: identification state, last arrangement kept
      chk("status", 32'h11F, rd);
      stop_test;
   end
   initial begin
      repeat (5000) @(posedge aclk);
      miscompares++;
      stop_test;
   end
endmodule : psr_router_bench
bind psr_router psr_router_sva #(.REFCLK_CYC(REFCLK_CYC)) u_sva (
   .aclk, .aresetn, .card_capability_code, .host_split_request, .standby_power_enable,
   .link_refclk_en, .link_reset_n);
`default_nettype wire

// ### test/psr_router_sva.sv
// Property checker for the split and reset router
`default_nettype none
module psr_router_sva #(
   parameter int REFCLK_CYC = 20
) (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic [3:0] card_capability_code,
   input wire logic [2:0] host_split_request,
   input wire logic       standby_power_enable,
   input wire logic [5:0] link_refclk_en,
   input wire logic [5:0] link_reset_n
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned wait_q;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Cycles since clock 0 became valid
   always_ff @(posedge aclk) begin
      if (!aresetn || !link_refclk_en[0]) begin
         wait_q <= 0;
      end else if (wait_q < REFCLK_CYC) begin
         wait_q <= wait_q + 1;
      end
   end
   AST_IDX45: assert property ((link_refclk_en[5:4] | link_reset_n[5:4]) == 2'h0)
      else $error("index 4 or 5 driven");
   AST_RST_CLK: assert property ((link_reset_n & ~link_refclk_en) == 6'h0)
      else $error("reset released without clock");
   AST_LEAD: assert property ($rose(link_reset_n[0]) |-> wait_q >= REFCLK_CYC)
      else $error("reset released too early");
   AST_SPLIT_HELD: assert property (standby_power_enable |-> $stable(host_split_request))
      else $error("split changed while powered");
   AST_ABSENT: assert property ((card_capability_code == 4'hF) [*8] |-> !standby_power_enable)
      else $error("power with no card");
   AST_X16_UNUSED: assert property ((card_capability_code == 4'h7) [*8] |-> link_reset_n[3:1] == 3'h0)
      else $error("unused link out of reset");
   AST_FORCE: assert property (standby_power_enable && host_split_request == 3'h6 |-> card_capability_code == 4'h4)
      else $error("force split on wrong card");
   AST_X16_SPLIT: assert property (standby_power_enable && card_capability_code == 4'h7 |-> host_split_request == 3'h0)
      else $error("x16 card not given 000");
   AST_POWER_UP: assert property ($rose(standby_power_enable) |-> link_refclk_en[0] && link_reset_n == 6'h0)
      else $error("bad power up");
   cover property ($rose(link_reset_n[0]));
   cover property (standby_power_enable && host_split_request == 3'h6);
   cover property (link_reset_n[3:0] == 4'hF);
endmodule : psr_router_sva
`default_nettype wire
